/* sws_top.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_top
  import sws_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host control-register write
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  // Host control-register read
  input wire logic [7:0] rd_addr_i,
  output logic [15:0] rd_data_o,
  // Host step reprogramming
  input wire logic prog_en_i,
  input wire logic [4:0] prog_index_i,
  input wire sws_step_type prog_step_i,
  // Control register bank
  output sws_ctl_bank_type ctl_regs_o,
  // Sequencer status
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic [4:0] step_index_o,
  // Sequencer write strobe
  output logic seq_wr_o,
  output logic [7:0] seq_addr_o,
  output logic [15:0] seq_data_o
);

  // Registers
  sws_state_type state_r;
  sws_state_type state_nxt;
  sws_ctl_bank_type ctl_r;
  logic [4:0] index_r;
  logic last_r;
  logic busy_r;
  logic done_r;
  logic refused_r;
  logic seq_wr_r;
  logic [7:0] seq_addr_r;
  logic [15:0] seq_data_r;
  logic [15:0] rd_data_r;

  // Decodes and selections
  logic launch_w;
  logic expire_w;
  logic finish_w;
  logic issue_w;
  logic [4:0] next_index_w;
  sws_step_type step_w;
  logic [4:0] seq_slot_w;
  logic [4:0] host_slot_w;
  logic [4:0] rd_slot_w;
  logic seq_hit_w;
  logic host_hit_w;
  logic [15:0] seq_old_w;
  logic [15:0] seq_new_w;
  logic [15:0] status_w;
  logic idle_w;
  logic run_w;
  logic launch_addr_w;
  logic launch_word_w;
  logic refuse_w;
  logic store_end_w;
  logic seq_mapped_w;
  logic host_mapped_w;
  logic rd_mapped_w;
  logic [7:0] step_addr_w;
  logic [3:0] step_code_w;
  logic step_last_w;

  // Stored program, read at the index of the step about to issue so that
  // its fields are ready in the cycle of the issue
  sws_step_store #(
    .STEPS(STEP_COUNT)
  ) u_store (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .prog_en_i(prog_en_i),
    .prog_index_i(prog_index_i),
    .prog_step_i(prog_step_i),
    .rd_index_i(next_index_w),
    .rd_step_o(step_w)
  );

  // Per-step wait; a start in the expiry cycle reloads the count, so
  // consecutive steps follow with no idle cycle between them
  sws_step_timer #(
    .TICK_CYCLES_P(TICK_CYCLES_P)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(issue_w),
    .wait_code_i(step_code_w),
    .expire_o(expire_w)
  );

  // Fields of the step about to issue; the store is read at the next
  // index, so these always describe the step that the next issue starts
  assign step_addr_w = step_w.step_addr;
  assign step_code_w = step_w.step_wait_code;
  assign step_last_w = step_w.step_last_flag;

  // State decodes
  assign idle_w = (state_r == SEQ_IDLE);
  assign run_w = (state_r == SEQ_RUN);

  // Launch decode: only the exact command word starts the run; any
  // other word at the launch address is ignored by this block
  assign launch_addr_w = (wr_addr_i == LAUNCH_ADDR);
  assign launch_word_w = (wr_data_i == LAUNCH_VALUE);
  assign launch_w = wr_en_i && launch_addr_w && launch_word_w;
  assign refuse_w = launch_w && run_w;

  // The run ends after the flagged step, or at the end of the store
  // when the host has cleared every last flag
  assign store_end_w = (index_r == LAST_INDEX);
  assign finish_w = run_w && expire_w && (last_r || store_end_w);

  // A new step is issued only once the previous wait has fully elapsed
  assign issue_w = (idle_w && launch_w) ||
    (run_w && expire_w && !finish_w);

  // Index of the step about to issue
  assign next_index_w = idle_w ? START_INDEX : (index_r + 5'h01);

  // Field update of the addressed register; a null or unmapped address
  // leaves every register alone
  assign seq_slot_w = sws_ctl_index(step_addr_w);
  assign seq_mapped_w = (seq_slot_w != 5'(REG_COUNT));
  assign seq_hit_w = issue_w && seq_mapped_w;
  assign seq_old_w = seq_mapped_w ? ctl_r[seq_slot_w[3:0]] : 16'h0000;
  assign seq_new_w = sws_field_merge(seq_old_w, step_w);

  // Direct host writes to mapped registers; writes elsewhere, the launch
  // address included, change no register
  assign host_slot_w = sws_ctl_index(wr_addr_i);
  assign host_mapped_w = (host_slot_w != 5'(REG_COUNT));
  assign host_hit_w = wr_en_i && host_mapped_w;

  // Read decode, launch address shows sequencer status
  assign rd_slot_w = sws_ctl_index(rd_addr_i);
  assign rd_mapped_w = (rd_slot_w != 5'(REG_COUNT));
  assign status_w = {7'h00, run_w, 3'h0, index_r};

  // Next state: two states suffice, the timer carries each wait and the
  // index carries the position in the program
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SEQ_IDLE:
      begin
        if (launch_w)
        begin
          state_nxt = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        if (finish_w)
        begin
          state_nxt = SEQ_IDLE;
        end
      end
      default:
      begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  // Sequencer state; busy is a registered copy of the running state, so
  // the host sees a clean level with no decode behind it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= SEQ_IDLE;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      busy_r <= (state_nxt == SEQ_RUN);
    end
  end

  // Index and last flag move only on issue, so they always name the
  // step whose wait is running
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      index_r <= START_INDEX;
      last_r <= 1'b0;
    end
    else if (issue_w)
    begin
      index_r <= next_index_w;
      last_r <= step_last_w;
    end
  end

  // Register bank: a sequencer write wins over a host write to one slot
  // A host write that meets a sequencer write to the same slot is lost
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (rst_i)
      begin
        ctl_r[i] <= CTL_RESET;
      end
      else if (seq_hit_w && (seq_slot_w == 5'(i)))
      begin
        ctl_r[i] <= seq_new_w;
      end
      else if (host_hit_w && (host_slot_w == 5'(i)))
      begin
        ctl_r[i] <= wr_data_i;
      end
    end
  end

  // One-cycle status pulses: end of run, and a launch refused while
  // busy, which leaves the run in progress untouched
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      done_r <= finish_w;
      refused_r <= refuse_w;
    end
  end

  // Write strobe of each issued step; address and value are kept for
  // null steps too, only the strobe stays low for them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_wr_r <= 1'b0;
      seq_addr_r <= 8'h00;
      seq_data_r <= 16'h0000;
    end
    else
    begin
      seq_wr_r <= seq_hit_w;
      if (issue_w)
      begin
        seq_addr_r <= step_addr_w;
        seq_data_r <= seq_new_w;
      end
    end
  end

  // Registered read port, one cycle behind the address; unmapped
  // addresses other than the launch address read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_r <= 16'h0000;
    end
    else if (rd_addr_i == LAUNCH_ADDR)
    begin
      rd_data_r <= status_w;
    end
    else if (rd_mapped_w)
    begin
      rd_data_r <= ctl_r[rd_slot_w[3:0]];
    end
    else
    begin
      rd_data_r <= 16'h0000;
    end
  end

  // Outputs straight from flip-flops, so a host sampling them never sees
  // a decode settling
  assign ctl_regs_o = ctl_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign refused_o = refused_r;
  assign step_index_o = index_r;
  assign seq_wr_o = seq_wr_r;
  assign seq_addr_o = seq_addr_r;
  assign seq_data_o = seq_data_r;
  assign rd_data_o = rd_data_r;

endmodule
`default_nettype wire

/* sws_pkg.sv */
package sws_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_TIME_NS = 62500;
  localparam int TICK_CYCLES =
    (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] WAIT_BASE_UNITS = 16'h0008;

  // Launch command and step store
  localparam logic [7:0] LAUNCH_ADDR = 8'h6F;
  localparam logic [15:0] LAUNCH_VALUE = 16'h0100;
  localparam logic [4:0] START_INDEX = 5'h00;
  localparam int STEP_COUNT = 25;
  localparam logic [4:0] LAST_INDEX = 5'h18;
  localparam logic [7:0] NULL_ADDR = 8'hFF;

  // Control registers reached by the sequencer
  localparam int REG_COUNT = 11;
  localparam logic [7:0] CTL_ADDR [REG_COUNT] = '{
    8'h04, 8'h05, 8'h0E, 8'h0F, 8'h12, 8'h16,
    8'h43, 8'h44, 8'h5A, 8'h5E, 8'h62};
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // Field positions inside the control registers
  localparam int MASTER_BIAS_ON_POS = 0;
  localparam int BIAS_CURRENT_SELECT_POS = 2;
  localparam int MIDRAIL_REFERENCE_ON_POS = 0;
  localparam int MIDRAIL_DIVIDER_SELECT_POS = 1;
  localparam int MIDRAIL_BUFFER_ON_POS = 6;
  localparam int PROCESSING_CLOCK_ON_POS = 1;
  localparam int CONVERTER_ON_POS = 2;
  localparam int CHARGE_PUMP_ON_POS = 0;
  localparam int OFFSET_SERVO_CHANNEL_ON_POS = 0;
  localparam int OFFSET_SERVO_STARTUP_TRIGGER_POS = 4;
  localparam int OUT_RIGHT_INPUT_STAGE_ON_POS = 0;
  localparam int OUT_RIGHT_MID_STAGE_ON_POS = 1;
  localparam int OUT_RIGHT_FINAL_STAGE_ON_POS = 2;
  localparam int OUT_RIGHT_UNSHORT_POS = 3;
  localparam int OUT_LEFT_INPUT_STAGE_ON_POS = 4;
  localparam int OUT_LEFT_MID_STAGE_ON_POS = 5;
  localparam int OUT_LEFT_FINAL_STAGE_ON_POS = 6;
  localparam int OUT_LEFT_UNSHORT_POS = 7;

  // One stored step
  typedef struct packed {
    logic [7:0] step_addr;
    logic [3:0] step_field_lsb;
    logic [2:0] step_field_size;
    logic [7:0] step_value;
    logic [3:0] step_wait_code;
    logic step_last_flag;
  } sws_step_type;

  typedef logic [REG_COUNT-1:0][15:0] sws_ctl_bank_type;

  typedef enum {SEQ_IDLE, SEQ_RUN} sws_state_type;

  // Build a step from its fields
  function automatic sws_step_type sws_mk(
    input logic [7:0] addr,
    input logic [3:0] lsb,
    input logic [2:0] size,
    input logic [7:0] value,
    input logic [3:0] code,
    input logic last
  );
    sws_step_type st;
    st = '{addr, lsb, size, value, code, last};
    return st;
  endfunction

  // Default start-up program
  function automatic sws_step_type sws_default_step(input logic [4:0] idx);
    sws_step_type st;
    st = sws_mk(NULL_ADDR, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0);
    case (idx)
      5'h00: st = sws_mk(8'h04, 4'h0, 3'h4, 8'h1A, 4'h0, 1'b0);
      5'h01: st = sws_mk(8'h05, 4'h0, 3'h7, 8'h47, 4'h6, 1'b0);
      5'h02: st = sws_mk(8'h05, 4'h1, 3'h1, 8'h01, 4'h0, 1'b0);
      5'h03: st = sws_mk(8'h04, 4'h0, 3'h0, 8'h01, 4'h0, 1'b0);
      5'h04: st = sws_mk(8'h0E, 4'h0, 3'h1, 8'h03, 4'h0, 1'b0);
      5'h05: st = sws_mk(8'h0F, 4'h0, 3'h1, 8'h03, 4'h0, 1'b0);
      5'h06: st = sws_mk(8'h16, 4'h1, 3'h0, 8'h01, 4'h0, 1'b0);
      5'h07: st = sws_mk(8'h12, 4'h2, 3'h1, 8'h03, 4'h5, 1'b0);
      5'h09: st = sws_mk(8'h04, 4'h4, 3'h0, 8'h00, 4'h0, 1'b0);
      5'h0A: st = sws_mk(8'h62, 4'h0, 3'h0, 8'h01, 4'h6, 1'b0);
      5'h0C: st = sws_mk(8'h5A, 4'h0, 3'h7, 8'h11, 4'h0, 1'b0);
      5'h0D: st = sws_mk(8'h5E, 4'h0, 3'h7, 8'h11, 4'h0, 1'b0);
      5'h0E: st = sws_mk(8'h5A, 4'h0, 3'h7, 8'h33, 4'h0, 1'b0);
      5'h0F: st = sws_mk(8'h5E, 4'h0, 3'h7, 8'h33, 4'h0, 1'b0);
      5'h10: st = sws_mk(8'h43, 4'h0, 3'h3, 8'h0F, 4'hC, 1'b0);
      5'h11: st = sws_mk(8'h44, 4'h0, 3'h7, 8'hF0, 4'h0, 1'b0);
      5'h13: st = sws_mk(8'h5A, 4'h0, 3'h7, 8'h77, 4'h0, 1'b0);
      5'h14: st = sws_mk(8'h5E, 4'h0, 3'h7, 8'h77, 4'h0, 1'b0);
      5'h15: st = sws_mk(8'h5A, 4'h0, 3'h7, 8'hFF, 4'h0, 1'b0);
      5'h16: st = sws_mk(8'h5E, 4'h0, 3'h7, 8'hFF, 4'h0, 1'b1);
      default: st = sws_mk(NULL_ADDR, 4'h0, 3'h0, 8'h00, 4'h0, 1'b0);
    endcase
    return st;
  endfunction

  // Bank slot of a control address, REG_COUNT when unmapped
  function automatic logic [4:0] sws_ctl_index(input logic [7:0] addr);
    logic [4:0] idx;
    idx = 5'(REG_COUNT);
    for (int i = 0; i < REG_COUNT; i++)
    begin
      if (CTL_ADDR[i] == addr)
      begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // Replace only the sized field of a register value
  function automatic logic [15:0] sws_field_merge(
    input logic [15:0] old_val,
    input sws_step_type st
  );
    logic [15:0] low_mask;
    logic [15:0] mask;
    logic [15:0] data;
    low_mask = 16'((17'h00001 << ({1'b0, st.step_field_size} + 4'h1))
      - 17'h00001);
    mask = low_mask << st.step_field_lsb;
    data = (({8'h00, st.step_value}) & low_mask) << st.step_field_lsb;
    return (old_val & ~mask) | data;
  endfunction

endpackage

/* sws_step_store.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_step_store
  import sws_pkg::*;
#(
  parameter int STEPS = STEP_COUNT
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reprogramming port
  input wire logic prog_en_i,
  input wire logic [4:0] prog_index_i,
  input wire sws_step_type prog_step_i,
  // Read port
  input wire logic [4:0] rd_index_i,
  output sws_step_type rd_step_o
);

  sws_step_type step_r [STEPS];

  // Read out of range gives a null step
  assign rd_step_o = (32'(rd_index_i) < STEPS) ? step_r[rd_index_i] :
    sws_mk(NULL_ADDR, 4'h0, 3'h0, 8'h00, 4'h0, 1'b1);

  // Reset loads the default program, the host may overwrite any entry
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < STEPS; i++)
    begin
      if (rst_i)
      begin
        step_r[i] <= sws_default_step(5'(i));
      end
      else if (prog_en_i && (prog_index_i == 5'(i)))
      begin
        step_r[i] <= prog_step_i;
      end
    end
  end

endmodule
`default_nettype wire

/* sws_step_timer.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_step_timer
  import sws_pkg::*;
#(
  parameter int unsigned TICK_CYCLES_P = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Start of a step and its wait code
  input wire logic start_i,
  input wire logic [3:0] wait_code_i,
  // High in the last cycle of the step
  output logic expire_o
);

  logic run_r;
  logic [15:0] pre_r;
  logic [15:0] unit_r;
  logic [15:0] units_w;
  logic [15:0] tick_last_w;

  // Units of 62.5us for the whole step, execution included
  assign units_w = (16'h0001 << wait_code_i) + WAIT_BASE_UNITS;
  assign tick_last_w = 16'(TICK_CYCLES_P - 1);
  assign expire_o = run_r && (pre_r == 16'h0000) && (unit_r == 16'h0000);

  // Prescaler and unit counter; a start restarts the count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_r <= 1'b0;
      pre_r <= 16'h0000;
      unit_r <= 16'h0000;
    end
    else if (start_i)
    begin
      run_r <= 1'b1;
      pre_r <= tick_last_w;
      unit_r <= units_w - 16'h0001;
    end
    else if (expire_o)
    begin
      run_r <= 1'b0;
    end
    else if (run_r)
    begin
      if (pre_r == 16'h0000)
      begin
        pre_r <= tick_last_w;
        unit_r <= unit_r - 16'h0001;
      end
      else
      begin
        pre_r <= pre_r - 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

/* sws_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_checker
  import sws_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Host write
  input wire logic wr_en_i,
  input wire logic [7:0] wr_addr_i,
  input wire logic [15:0] wr_data_i,
  // Bank and status
  input wire sws_ctl_bank_type ctl_regs_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic [4:0] step_index_o,
  input wire logic seq_wr_o,
  input wire logic [7:0] seq_addr_o
);
  // Launch decode
  wire logic go;
  assign go = wr_en_i && wr_addr_i == 8'h6F && wr_data_i == 16'h0100;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_launch_start: assert property (
    go && !busy_o |=> busy_o && step_index_o == 5'h00)
    else $error("launch did not start at step 0");
  a_launch_refused: assert property (
    go && busy_o |=> refused_o)
    else $error("launch while busy not refused");
  a_done_end: assert property (
    done_o |-> !busy_o && $past(busy_o))
    else $error("done without end of run");
  a_done_pulse: assert property (
    done_o |=> !done_o)
    else $error("done longer than one cycle");
  a_null_quiet: assert property (
    seq_wr_o |-> seq_addr_o != 8'hFF)
    else $error("strobe on null step");
  a_bank_hold: assert property (
    !$past(wr_en_i) && !seq_wr_o |-> $stable(ctl_regs_o))
    else $error("bank changed with no write");
  a_index_up: assert property (
    busy_o && $past(busy_o) && step_index_o != $past(step_index_o)
    |-> step_index_o == $past(step_index_o) + 5'h01)
    else $error("step index skipped");
  a_idle_quiet: assert property (
    !busy_o && !$past(busy_o) |-> !seq_wr_o)
    else $error("write while idle");
  a_step_gap: assert property (
    seq_wr_o |=> !seq_wr_o [*8])
    else $error("steps closer than minimum");
endmodule
`default_nettype wire

/* sws_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_host
  import sws_pkg::*;
(
  // Clock and read data
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  // Host write and read
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic [7:0] rd_addr_o,
  // Step reprogramming
  output logic prog_en_o,
  output logic [4:0] prog_index_o,
  output sws_step_type prog_step_o
);
  // Idle at time zero
  initial
  begin
    wr_en_o = 1'b0;
    wr_addr_o = 8'h00;
    wr_data_o = 16'h0000;
    rd_addr_o = 8'h00;
    prog_en_o = 1'b0;
    prog_index_o = 5'h00;
    prog_step_o = '0;
  end
  // One register write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    wr_en_o = 1'b1;
    wr_addr_o = a;
    wr_data_o = d;
    @(negedge clk_i);
    wr_en_o = 1'b0;
    wr_addr_o = ~a;
    wr_data_o = ~d;
  endtask
  // Replace one stored step
  task automatic pg(input logic [4:0] i, input sws_step_type s);
    @(negedge clk_i);
    prog_en_o = 1'b1;
    prog_index_o = i;
    prog_step_o = s;
    @(negedge clk_i);
    prog_en_o = 1'b0;
    prog_index_o = ~i;
    prog_step_o = ~s;
  endtask
  // Register read, data one cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(negedge clk_i);
    rd_addr_o = a;
    @(negedge clk_i);
    q = rd_data_i;
  endtask
endmodule
`default_nettype wire

/* sws_top_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module sws_top_bench;
  import sws_pkg::*;
  localparam int TK = 1;
  localparam logic [7:0] EA [23] = '{
    8'h04, 8'h05, 8'h05, 8'h04, 8'h0E, 8'h0F, 8'h16, 8'h12,
    8'hFF, 8'h04, 8'h62, 8'hFF, 8'h5A, 8'h5E, 8'h5A, 8'h5E,
    8'h43, 8'h44, 8'hFF, 8'h5A, 8'h5E, 8'h5A, 8'h5E};
  localparam logic [7:0] ED [23] = '{
    8'h1A, 8'h47, 8'h43, 8'h1B, 8'h03, 8'h03, 8'h02, 8'h0C,
    8'h00, 8'h0B, 8'h01, 8'h00, 8'h11, 8'h11, 8'h33, 8'h33,
    8'h0F, 8'hF0, 8'h00, 8'h77, 8'h77, 8'hFF, 8'hFF};
  localparam logic [15:0] FB [11] = '{
    16'h000B, 16'h0043, 16'h0003, 16'h0003, 16'h000C, 16'h0002,
    16'h000F, 16'h00F0, 16'h00FF, 16'h00FF, 16'h0001};
  logic clk = 1'b0;
  logic rst_i = 1'b1;
  int n_errors = 0;
  int total_checks = 0;
  logic wr_en, prog_en, busy, done, refused, seq_wr;
  logic [7:0] wr_addr, rd_addr, seq_addr;
  logic [15:0] wr_data, rd_data, seq_data, q;
  logic [4:0] prog_index, idx;
  sws_step_type prog_step;
  sws_ctl_bank_type bank;
  // Clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  sws_host host (.clk_i(clk), .rd_data_i(rd_data), .wr_en_o(wr_en),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
    .prog_en_o(prog_en), .prog_index_o(prog_index),
    .prog_step_o(prog_step));
  sws_top #(.TICK_CYCLES_P(TK)) uut (.clk_i(clk), .rst_i(rst_i),
    .wr_en_i(wr_en), .wr_addr_i(wr_addr), .wr_data_i(wr_data),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .prog_en_i(prog_en),
    .prog_index_i(prog_index), .prog_step_i(prog_step),
    .ctl_regs_o(bank), .busy_o(busy), .done_o(done),
    .refused_o(refused), .step_index_o(idx), .seq_wr_o(seq_wr),
    .seq_addr_o(seq_addr), .seq_data_o(seq_data));
  // Step length in cycles
  function automatic int cyc(input int k);
    int c;
    c = (k == 1 || k == 10) ? 6 : (k == 7) ? 5 : (k == 16) ? 12 : 0;
    return ((1 << c) + 8) * TK;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Idle state after reset
  task automatic t_reset;
    repeat (16) @(negedge clk);
    rst_i = 1'b0;
    chk(16'(busy), 16'h0000);
    for (int i = 0; i < 11; i++)
      chk(bank[i], 16'h0000);
  endtask
  // Full default run with exact step timing
  task automatic t_run;
    host.wr(8'h6F, 16'h0100);
    for (int k = 0; k < 23; k++)
    begin
      if (k > 0)
      begin
        repeat (cyc(k - 1) - 1) @(negedge clk);
        chk(16'(idx), 16'(k - 1));
        @(negedge clk);
      end
      chk(16'(idx), 16'(k));
      chk(16'(seq_addr), 16'(EA[k]));
      chk(16'(seq_wr), 16'(EA[k] != 8'hFF));
      if (EA[k] != 8'hFF)
        chk(seq_data, 16'(ED[k]));
    end
    repeat (8) @(negedge clk);
    chk(16'({busy, done}), 16'h0002);
    @(negedge clk);
    chk(16'({busy, done}), 16'h0001);
    for (int i = 0; i < 11; i++)
      chk(bank[i], FB[i]);
    chk(bank[8], FB[8]);
  endtask
  // Second launch, mid-run reset, other writes and reads
  task automatic t_refuse;
    host.wr(8'h6F, 16'h0100);
    host.wr(8'h6F, 16'h0100);
    chk(16'({refused, 3'h0, idx}), 16'h0100);
    @(negedge clk);
    rst_i = 1'b1;
    repeat (3) @(negedge clk);
    rst_i = 1'b0;
    chk(16'(busy), 16'h0000);
    chk(bank[0], 16'h0000);
    host.wr(8'h6F, 16'h0119);
    host.wr(8'h33, 16'hFFFF);
    host.wr(8'h04, 16'hFFFF);
    chk(16'(busy), 16'h0000);
    host.rd(8'h04, q);
    chk(q, 16'hFFFF);
    host.rd(8'h33, q);
    chk(q, 16'h0000);
    host.rd(8'h6F, q);
    chk(q, 16'h0000);
  endtask
  // Reprogrammed one-step run: field merge and last flag
  task automatic t_prog;
    host.pg(5'h00, '{8'h04, 4'h4, 3'h2, 8'hFD, 4'h0, 1'b1});
    host.wr(8'h6F, 16'h0100);
    chk(bank[0], 16'hFFDF);
    chk(16'(seq_wr), 16'h0001);
    host.rd(8'h6F, q);
    chk(q, 16'h0100);
    repeat (6) @(negedge clk);
    chk(16'(busy), 16'h0001);
    @(negedge clk);
    chk(16'({busy, done, 3'h0, idx}), 16'h0100);
    chk(bank[1], 16'h0000);
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
  // Main sequence
  initial
  begin
    t_reset();
    t_run();
    t_refuse();
    t_prog();
    conclude();
  end
endmodule
bind sws_top sws_checker chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
  .ctl_regs_o(ctl_regs_o), .busy_o(busy_o), .done_o(done_o),
  .refused_o(refused_o), .step_index_o(step_index_o),
  .seq_wr_o(seq_wr_o), .seq_addr_o(seq_addr_o));
`default_nettype wire
